// *** src/scan_tap_pkg.sv ***
// constants for the sram boundary-scan test access port
// assumes one system clock that samples all test pins
package scan_tap_pkg;
    localparam int unsigned IR_WIDTH = 3;
    localparam int unsigned ID_WIDTH = 32;
    localparam int unsigned BSR_WIDTH = 72;
    localparam int unsigned ADDR_WIDTH = 17;

    localparam logic [2:0] INSTR_EXTEST = 3'h0;
    localparam logic [2:0] INSTR_IDCODE = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INSTR_SAMPLE = 3'h4;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;

    // identification word field positions
    localparam int unsigned ID_REV_LSB = 28;
    localparam int unsigned ID_DEPTH_LSB = 23;
    localparam int unsigned ID_WIDTHF_LSB = 18;
    localparam int unsigned ID_DEVICE_LSB = 12;
    localparam int unsigned ID_VENDOR_LSB = 1;
    localparam int unsigned ID_PRESENT_BIT = 0;

    // identity values: arbitrary neutral values
    localparam logic [3:0] ID_REVISION = 4'h1;
    localparam logic [4:0] ID_DEPTH = 5'h13;
    localparam logic [4:0] ID_WIDTHF = 5'h04;
    localparam logic [5:0] ID_DEVICE = 6'h00;
    localparam logic [10:0] ID_VENDOR = 11'h2aa;

    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
        ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_t;
endpackage

// *** src/tap_ctrl_if.sv ***
// signals between the tap state machine and the scan data path
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface tap_ctrl_if;
    logic tck_rise;
    logic tms;
    logic in_reset;
    logic capture_dr;
    logic shift_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;

    modport fsm (
        input tck_rise, tms,
        output in_reset, capture_dr, shift_dr, capture_ir, shift_ir, update_ir
    );
    modport core (
        output tck_rise, tms,
        input in_reset, capture_dr, shift_dr, capture_ir, shift_ir, update_ir
    );
endinterface
`default_nettype wire

// *** src/tap_state_machine.sv ***
// sixteen-state test access port controller
// assumes tck_rise is a one-cycle pulse with tms already synchronised
`timescale 1ns/1ps
`default_nettype none
module tap_state_machine (
    input wire logic clk_sys,   // system clock
    input wire logic sys_rst,   // synchronous reset, active high
    tap_ctrl_if.fsm ctrl        // edge in, state decodes out
);
    scan_tap_pkg::tap_state_t state_q;
    scan_tap_pkg::tap_state_t state_d;

    function automatic scan_tap_pkg::tap_state_t next_state(
        input scan_tap_pkg::tap_state_t s, input logic m);
        case (s)
            scan_tap_pkg::ST_RESET: return m ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_IDLE;
            scan_tap_pkg::ST_IDLE: return m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
            scan_tap_pkg::ST_SEL_DR: return m ? scan_tap_pkg::ST_SEL_IR : scan_tap_pkg::ST_CAP_DR;
            scan_tap_pkg::ST_CAP_DR: return m ? scan_tap_pkg::ST_EXIT1_DR
                                              : scan_tap_pkg::ST_SHIFT_DR;
            scan_tap_pkg::ST_SHIFT_DR: return m ? scan_tap_pkg::ST_EXIT1_DR
                                                : scan_tap_pkg::ST_SHIFT_DR;
            scan_tap_pkg::ST_EXIT1_DR: return m ? scan_tap_pkg::ST_UPD_DR
                                                : scan_tap_pkg::ST_PAUSE_DR;
            scan_tap_pkg::ST_PAUSE_DR: return m ? scan_tap_pkg::ST_EXIT2_DR
                                                : scan_tap_pkg::ST_PAUSE_DR;
            scan_tap_pkg::ST_EXIT2_DR: return m ? scan_tap_pkg::ST_UPD_DR
                                                : scan_tap_pkg::ST_SHIFT_DR;
            scan_tap_pkg::ST_UPD_DR: return m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
            scan_tap_pkg::ST_SEL_IR: return m ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_CAP_IR;
            scan_tap_pkg::ST_CAP_IR: return m ? scan_tap_pkg::ST_EXIT1_IR
                                              : scan_tap_pkg::ST_SHIFT_IR;
            scan_tap_pkg::ST_SHIFT_IR: return m ? scan_tap_pkg::ST_EXIT1_IR
                                                : scan_tap_pkg::ST_SHIFT_IR;
            scan_tap_pkg::ST_EXIT1_IR: return m ? scan_tap_pkg::ST_UPD_IR
                                                : scan_tap_pkg::ST_PAUSE_IR;
            scan_tap_pkg::ST_PAUSE_IR: return m ? scan_tap_pkg::ST_EXIT2_IR
                                                : scan_tap_pkg::ST_PAUSE_IR;
            scan_tap_pkg::ST_EXIT2_IR: return m ? scan_tap_pkg::ST_UPD_IR
                                                : scan_tap_pkg::ST_SHIFT_IR;
            scan_tap_pkg::ST_UPD_IR: return m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
            default: return scan_tap_pkg::ST_RESET;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        if (ctrl.tck_rise) begin
            state_d = next_state(state_q, ctrl.tms); // [RULE13]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= scan_tap_pkg::ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign ctrl.in_reset = (state_q == scan_tap_pkg::ST_RESET);
    assign ctrl.capture_dr = (state_q == scan_tap_pkg::ST_CAP_DR);
    assign ctrl.shift_dr = (state_q == scan_tap_pkg::ST_SHIFT_DR);
    assign ctrl.capture_ir = (state_q == scan_tap_pkg::ST_CAP_IR);
    assign ctrl.shift_ir = (state_q == scan_tap_pkg::ST_SHIFT_IR);
    assign ctrl.update_ir = (state_q == scan_tap_pkg::ST_UPD_IR);
endmodule
`default_nettype wire

// *** src/sram_boundary_scan_tap.sv ***
// boundary-scan test access port of a x36 synchronous burst sram
// assumes test pins are asynchronous to clk_sys and much slower than it
// Operation
// (RULE1) registers: 3-bit instruction, 1-bit bypass, 32-bit id, 72-bit boundary chain
// (RULE2) code 000 captures pins, shifts boundary chain, turns sram outputs off
// (RULE3) code 001 loads and shifts the id word, sram unaffected
// (RULE4) code 010 captures pins, shifts boundary chain, turns sram outputs off
// (RULE5) code 100 captures pins and shifts boundary chain; no preload
// (RULE6) controller never loads codes 011, 101 or 110; here ir_q loads them on update and decodes them as bypass
// (RULE7) code 111 puts one bypass bit between data in and out
// (RULE8) chain 1-9 address, 10 parity a, 11-18 byte a, 19 sleep, 20-28 byte b, 29-30 address
// (RULE9) chain 31-44 advance, strobes, oe, byte/global write, clock, enables, byte writes
// (RULE10) chain 45-46 address, 47-55 byte c, 56 flow, 57-65 byte d, 66 order, 67-72 address
// (RULE11) id word: revision 31:28, depth 27:23, width 22:18, device 17:12
// (RULE12) id word: vendor code 11:1, bit 0 constant one
// (RULE13) standard sixteen states on rising test clock; output changes on falling, off otherwise
// (RULE14) entering test-logic-reset selects the identification instruction
`timescale 1ns/1ps
`default_nettype none
module sram_boundary_scan_tap (
    input wire logic clk_sys,                  // system clock, 25 MHz
    input wire logic sys_rst,                  // synchronous reset, active high
    input wire logic tck,                      // test clock pin
    input wire logic tms,                      // test mode select pin
    input wire logic tdi,                      // test data in pin
    output logic tdo,                          // test data out
    output logic tdo_oe_n,                     // low while tdo is driven
    output logic sram_outputs_off,             // high forces sram outputs to high-z
    input wire logic [16:0] sram_address_bit,  // upper address balls
    input wire logic low_address_bit_one,      // address bit 1
    input wire logic low_address_bit_two,      // address bit 0
    input wire logic [7:0] byte_a_data,        // data byte a
    input wire logic [7:0] byte_b_data,        // data byte b
    input wire logic [7:0] byte_c_data,        // data byte c
    input wire logic [7:0] byte_d_data,        // data byte d
    input wire logic byte_a_parity,            // parity byte a
    input wire logic byte_b_parity,            // parity byte b
    input wire logic byte_c_parity,            // parity byte c
    input wire logic byte_d_parity,            // parity byte d
    input wire logic sleep_input,              // sleep pin
    input wire logic flow_through_select,      // flow-through pin
    input wire logic burst_order_select,       // burst order pin
    input wire logic burst_advance,            // burst advance pin
    input wire logic processor_strobe,         // processor address strobe
    input wire logic controller_strobe,        // controller address strobe
    input wire logic output_enable,            // output enable pin
    input wire logic byte_write_enable,        // byte write enable pin
    input wire logic global_write,             // global write pin
    input wire logic sram_clock,               // sram clock pin level
    input wire logic chip_enable_two,          // chip enable 2
    input wire logic [3:0] byte_write,         // byte writes, [0]=a .. [3]=d
    input wire logic chip_enable_one,          // chip enable 1
    input wire logic chip_enable_zero          // chip enable 0
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and test clock edge detect
    logic [scan_tap_pkg::SYNC_STAGES-1:0] tck_sync_q;
    logic [scan_tap_pkg::SYNC_STAGES-1:0] tms_sync_q;
    logic [scan_tap_pkg::SYNC_STAGES-1:0] tdi_sync_q;
    logic tck_prev_q;
    logic tck_fall;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tck_sync_q <= '0;
            tms_sync_q <= '1;
            tdi_sync_q <= '0;
            tck_prev_q <= 1'b0;
        end else begin
            tck_sync_q <= {tck_sync_q[0], tck};
            tms_sync_q <= {tms_sync_q[0], tms};
            tdi_sync_q <= {tdi_sync_q[0], tdi};
            tck_prev_q <= tck_sync_q[1];
        end
    end

    tap_ctrl_if ctrl ();

    assign ctrl.tck_rise = tck_sync_q[1] & ~tck_prev_q; // [RULE13]
    assign ctrl.tms = tms_sync_q[1];
    assign tck_fall = ~tck_sync_q[1] & tck_prev_q;

    tap_state_machine u_fsm (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ctrl(ctrl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // instruction register
    logic [scan_tap_pkg::IR_WIDTH-1:0] ir_shift_q; // [RULE1]
    logic [scan_tap_pkg::IR_WIDTH-1:0] ir_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ir_shift_q <= scan_tap_pkg::IR_CAPTURE_VALUE;
            ir_q <= scan_tap_pkg::INSTR_IDCODE;
        end else begin
            // held at the id code for as long as the tap sits in reset
            if (ctrl.in_reset) begin
                ir_q <= scan_tap_pkg::INSTR_IDCODE; // [RULE14]
            end else if (ctrl.tck_rise && ctrl.update_ir) begin
                ir_q <= ir_shift_q;
            end
            if (!ctrl.tck_rise) begin
                ir_shift_q <= ir_shift_q;
            end else if (ctrl.capture_ir) begin
                ir_shift_q <= scan_tap_pkg::IR_CAPTURE_VALUE;
            end else if (ctrl.shift_ir) begin
                ir_shift_q <= {tdi_sync_q[1], ir_shift_q[scan_tap_pkg::IR_WIDTH-1:1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // instruction decode; unused codes fall back to bypass
    logic sel_bsr;
    logic sel_id;

    always_comb begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        case (ir_q)
            scan_tap_pkg::INSTR_EXTEST: sel_bsr = 1'b1;   // [RULE2]
            scan_tap_pkg::INSTR_IDCODE: sel_id = 1'b1;    // [RULE3]
            scan_tap_pkg::INSTR_SAMPLE_Z: sel_bsr = 1'b1; // [RULE4]
            scan_tap_pkg::INSTR_SAMPLE: sel_bsr = 1'b1;   // [RULE5]
            default: sel_bsr = 1'b0;                       // [RULE6] [RULE7]
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sram_outputs_off <= 1'b0;
        end else begin
            sram_outputs_off <= (ir_q == scan_tap_pkg::INSTR_EXTEST) // [RULE2]
                             | (ir_q == scan_tap_pkg::INSTR_SAMPLE_Z); // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin ring, written from chain bit 72 down to bit 1 (bit 1 leaves first)
    logic [scan_tap_pkg::BSR_WIDTH-1:0] ring;
    logic [scan_tap_pkg::ID_WIDTH-1:0] id_word;

    assign ring = {
        low_address_bit_two, low_address_bit_one,                    // 72-71 [RULE10]
        sram_address_bit[16:13], burst_order_select,                 // 70-66 [RULE10]
        byte_d_parity, byte_d_data, flow_through_select,             // 65-56 [RULE10]
        byte_c_data, byte_c_parity, sram_address_bit[12:11],         // 55-45 [RULE10]
        chip_enable_zero, chip_enable_one, byte_write[3], byte_write[2], // 44-41 [RULE9]
        byte_write[1], byte_write[0], chip_enable_two, sram_clock,   // 40-37 [RULE9]
        global_write, byte_write_enable, output_enable,              // 36-34 [RULE9]
        controller_strobe, processor_strobe, burst_advance,          // 33-31 [RULE9]
        sram_address_bit[10:9], byte_b_parity, byte_b_data,          // 30-20 [RULE8]
        sleep_input, byte_a_data, byte_a_parity, sram_address_bit[8:0] // 19-1 [RULE8]
    };

    assign id_word = {scan_tap_pkg::ID_REVISION, scan_tap_pkg::ID_DEPTH,   // [RULE11]
                      scan_tap_pkg::ID_WIDTHF, scan_tap_pkg::ID_DEVICE,   // [RULE11]
                      scan_tap_pkg::ID_VENDOR, 1'b1};                     // [RULE12]

    ////////////////////////////////////////////////////////////////////////////////
    // data registers
    logic [scan_tap_pkg::BSR_WIDTH-1:0] bsr_q;
    logic [scan_tap_pkg::ID_WIDTH-1:0] id_q;
    logic bypass_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bsr_q <= '0;
        end else if (ctrl.tck_rise && sel_bsr) begin
            if (ctrl.capture_dr) begin
                bsr_q <= ring; // [RULE2] [RULE4] [RULE5]
            end else if (ctrl.shift_dr) begin
                bsr_q <= {tdi_sync_q[1], bsr_q[scan_tap_pkg::BSR_WIDTH-1:1]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            id_q <= '0;
        end else if (ctrl.tck_rise && sel_id) begin
            if (ctrl.capture_dr) begin
                id_q <= id_word; // [RULE3]
            end else if (ctrl.shift_dr) begin
                id_q <= {tdi_sync_q[1], id_q[scan_tap_pkg::ID_WIDTH-1:1]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bypass_q <= 1'b0;
        end else if (ctrl.tck_rise && !sel_bsr && !sel_id) begin
            if (ctrl.capture_dr) begin
                bypass_q <= 1'b0;
            end else if (ctrl.shift_dr) begin
                bypass_q <= tdi_sync_q[1]; // [RULE7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial output, moved on the falling test clock
    logic dr_lsb;

    always_comb begin
        if (sel_bsr) begin
            dr_lsb = bsr_q[0];
        end else if (sel_id) begin
            dr_lsb = id_q[0];
        end else begin
            dr_lsb = bypass_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            tdo <= ctrl.shift_ir ? ir_shift_q[0] : dr_lsb;      // [RULE13]
            tdo_oe_n <= ~(ctrl.shift_ir | ctrl.shift_dr);        // [RULE13]
        end
    end
endmodule
`default_nettype wire

// *** verif/scan_tap_chk.sv ***
// assertion checker for the scan tap top ports
// assumes clk_sys samples the test pins; bound to the top module
`timescale 1ns/1ps
`default_nettype none
module scan_tap_chk (
    input wire logic clk_sys,         // system clock
    input wire logic sys_rst,         // synchronous reset
    input wire logic tck,             // test clock pin
    input wire logic tms,             // test mode select pin
    input wire logic tdo,             // test data out
    input wire logic tdo_oe_n,        // low while tdo driven
    input wire logic sram_outputs_off // sram outputs forced off
);
    logic tck_q;
    logic [3:0] since_fall_q;
    logic [3:0] since_rise_q;
    logic [2:0] ones_q;
    logic fresh_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        tck_q <= tck;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (tck_q && !tck)) since_fall_q <= 4'h0;
        else if (since_fall_q != 4'hf) since_fall_q <= since_fall_q + 4'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (!tck_q && tck)) since_rise_q <= 4'h0;
        else if (since_rise_q != 4'hf) since_rise_q <= since_rise_q + 4'h1;
    end
    // run of test clock rises seen with mode select high
    always_ff @(posedge clk_sys) begin
        if (sys_rst) ones_q <= 3'h0;
        else if (tck && !tck_q) ones_q <= !tms ? 3'h0 : (ones_q == 3'h7 ? 3'h7 : ones_q + 3'h1);
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) fresh_q <= 1'b1;
        else if (!tdo_oe_n) fresh_q <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_first_drive;
        $fell(tdo_oe_n) ##0 fresh_q;
    endsequence
    chk_tdo_after_fall: assert property (
        $changed(tdo) |-> since_fall_q inside {[4'h1:4'h5]}) else $error("tdo moved off a fall");
    chk_oe_after_fall: assert property (
        $fell(tdo_oe_n) |-> since_fall_q inside {[4'h1:4'h5]}) else $error("drive began off a fall");
    chk_oe_release_stands: assert property (
        $rose(tdo_oe_n) |=> $stable(tdo_oe_n)[*3]) else $error("release did not stand");
    chk_off_after_rise: assert property (
        $changed(sram_outputs_off) |-> since_rise_q inside {[4'h1:4'h6]}) else $error("off moved late");
    chk_release_quiet: assert property (
        $fell(sys_rst) |-> tdo_oe_n && !tdo && !sram_outputs_off) else $error("bad reset outputs");
    chk_first_bit_one: assert property (
        s_first_drive |-> tdo) else $error("first shifted bit not one");
    chk_tap_reset_off: assert property (
        ones_q == 3'h5 |-> ##[0:12] !sram_outputs_off) else $error("tap reset left outputs off");
    chk_tap_reset_drive: assert property (
        ones_q == 3'h5 |-> ##[0:12] tdo_oe_n) else $error("tap reset left tdo driven");
endmodule
bind sram_boundary_scan_tap scan_tap_chk u_scan_tap_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .sram_outputs_off(sram_outputs_off));
`default_nettype wire

// *** verif/tap_controller_model.sv ***
// model of the external boundary-scan controller driving the tap pins
// assumes callers enter its tasks just after a clk_sys rising edge
`timescale 1ns/1ps
`default_nettype none
module tap_controller_model (
    input wire logic clk_sys,  // paces the test clock
    output var logic tck,      // test clock, still between frames
    output var logic tms,      // test mode select
    output var logic tdi,      // test data in
    input wire logic tdo,      // test data out
    input wire logic tdo_oe_n  // low while tdo driven
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one test clock of 320 ns; a released tdo reads as the inverse of its last value
    task automatic step(input logic m, input logic d, output logic q, output logic qn);
        tms = m;
        tdi = d;
        repeat (4) @(posedge clk_sys);
        #1 tck = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 q = tdo ^ tdo_oe_n;
        qn = tdo_oe_n;
        @(posedge clk_sys);
        #1 tck = 1'b0;
    endtask
    // from idle: capture, shift n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [71:0] din,
            output logic [71:0] dout, output logic drove);
        logic q;
        logic qn;
        dout = '0;
        drove = 1'b1;
        step(1'b1, 1'b0, q, qn);
        if (ir) step(1'b1, 1'b0, q, qn);
        step(1'b0, 1'b0, q, qn);
        step(1'b0, 1'b0, q, qn);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], q, qn);
            dout[k] = q;
            drove = drove & ~qn;
        end
        step(1'b1, 1'b0, q, qn);
        step(1'b0, 1'b0, q, qn);
    endtask
    task automatic reset_tap();
        logic q;
        logic qn;
        repeat (5) step(1'b1, 1'b0, q, qn);
        step(1'b0, 1'b0, q, qn);
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the sram boundary-scan tap
// assumes the controller model in tap_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys;
    logic sys_rst;
    logic [71:0] ring;
    wire logic tck, tms, tdi, tdo, tdo_oe_n, sram_outputs_off;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // ring[i-1] is the pin at chain position i
    sram_boundary_scan_tap i_sram_boundary_scan_tap (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .sram_outputs_off(sram_outputs_off),
        .sram_address_bit({ring[69:66], ring[45:44], ring[29:28], ring[8:0]}),
        .low_address_bit_one(ring[70]), .low_address_bit_two(ring[71]),
        .byte_a_data(ring[17:10]), .byte_b_data(ring[26:19]), .byte_c_data(ring[54:47]),
        .byte_d_data(ring[63:56]), .byte_a_parity(ring[9]), .byte_b_parity(ring[27]),
        .byte_c_parity(ring[46]), .byte_d_parity(ring[64]), .sleep_input(ring[18]),
        .flow_through_select(ring[55]), .burst_order_select(ring[65]),
        .burst_advance(ring[30]), .processor_strobe(ring[31]), .controller_strobe(ring[32]),
        .output_enable(ring[33]), .byte_write_enable(ring[34]), .global_write(ring[35]),
        .sram_clock(ring[36]), .chip_enable_two(ring[37]), .byte_write(ring[41:38]),
        .chip_enable_one(ring[42]), .chip_enable_zero(ring[43]));
    tap_controller_model ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check_vec(input logic [71:0] got, input logic [71:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            $display("MISMATCH at %0t: run hung", $time);
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic load_ir(input logic [2:0] code);
        logic [71:0] got;
        logic drove;
        ctl.scan(1'b1, 3, {69'h0, code}, got, drove);
        check_vec(got, 72'h1, "instruction capture");
    endtask
    task automatic read_id();
        logic [71:0] got;
        logic [71:0] exp;
        logic drove;
        exp = {40'h0, scan_tap_pkg::ID_REVISION, scan_tap_pkg::ID_DEPTH, scan_tap_pkg::ID_WIDTHF,
            scan_tap_pkg::ID_DEVICE, scan_tap_pkg::ID_VENDOR, 1'b1};
        ctl.scan(1'b0, 32, 72'h0, got, drove);
        check_vec(got, exp, "id word");
        check_bit(drove, 1'b1, "tdo driven while shifting");
        check_bit(tdo_oe_n, 1'b1, "tdo released in idle");
    endtask
    task automatic test_id_reset();
        ctl.reset_tap();
        read_id();
        check_bit(sram_outputs_off, 1'b0, "outputs on with id");
        $display("test id after reset done");
    endtask
    task automatic test_bypass();
        logic [71:0] got;
        logic drove;
        load_ir(scan_tap_pkg::INSTR_BYPASS);
        ctl.scan(1'b0, 8, 72'ha5, got, drove);
        check_vec(got, 72'h4a, "bypass path");
        check_bit(sram_outputs_off, 1'b0, "outputs on in bypass");
        $display("test bypass done");
    endtask
    task automatic test_ring();
        logic [2:0] code [3];
        logic [71:0] pat [3];
        logic [71:0] got;
        logic drove;
        code = '{scan_tap_pkg::INSTR_EXTEST, scan_tap_pkg::INSTR_SAMPLE_Z,
            scan_tap_pkg::INSTR_SAMPLE};
        pat = '{72'h965a3cf00fc3a51e87, 72'h69a5c30ff03c5ae178, 72'h0f123456789abcdef0};
        for (int i = 0; i < 3; i++) begin
            ring = pat[i];
            load_ir(code[i]);
            check_bit(sram_outputs_off, code[i] != 3'h4, "outputs off");
            ctl.scan(1'b0, 72, ~pat[i], got, drove);
            check_vec(got, pat[i], "boundary chain");
            check_bit(drove, 1'b1, "tdo driven in chain shift");
        end
        $display("test boundary chain done");
    endtask
    task automatic test_tap_reset();
        load_ir(scan_tap_pkg::INSTR_SAMPLE_Z);
        check_bit(sram_outputs_off, 1'b1, "outputs off before tap reset");
        ctl.reset_tap();
        check_bit(sram_outputs_off, 1'b0, "outputs on after tap reset");
        read_id();
        $display("test tap reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        ring = '0;
        repeat (16) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        test_id_reset();
        test_bypass();
        test_ring();
        test_tap_reset();
        end_sim();
    end
endmodule
`default_nettype wire
